// [rtl/eic_map.vh]
// Register map, field positions and reset values of the extra interrupt control block.
// Assumes an 8-bit special-function-register space with bit addressing at base + bit.
`ifndef EIC_MAP_VH
`define EIC_MAP_VH

// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define EIC_XCTL_ADDR 8'hC0
`define EIC_PORT_ADDR 8'hD8
`define EIC_ADDR_BASE_MASK 8'hF8
`define EIC_ADDR_BIT_MASK 8'h07

// ----------------------------------------------------------------
// Fields of extra_interrupt_control
// ----------------------------------------------------------------
`define EIC_B_PRIORITY_HIGH 7
`define EIC_B_ENABLE 6
`define EIC_B_REQUEST_FLAG 5
`define EIC_B_EDGE_SELECT 4
`define EIC_A_PRIORITY_HIGH 3
`define EIC_A_ENABLE 2
`define EIC_A_REQUEST_FLAG 1
`define EIC_A_EDGE_SELECT 0

// ----------------------------------------------------------------
// Port pins carrying the two request inputs
// ----------------------------------------------------------------
`define EIC_PIN_A 2
`define EIC_PIN_B 3
`define EIC_PORT_WIDTH 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EIC_XCTL_RESET 8'h00
`define EIC_PORT_RESET 4'hF

// ----------------------------------------------------------------
// Vectors and polling positions
// ----------------------------------------------------------------
`define EIC_A_VECTOR 8'h33
`define EIC_B_VECTOR 8'h3B
`define EIC_A_POLL 3'h6
`define EIC_B_POLL 3'h7

`endif

// [rtl/eic_sync.v]
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes inputs arrive from pins outside the core clock domain.
`timescale 1ns/10ps

module eic_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Levels
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] stageOne;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stageOne <= RESET_VALUE;
            syncOut <= RESET_VALUE;
        end else begin
            stageOne <= asyncIn;
            syncOut <= stageOne;
        end
    end

endmodule // eic_sync

// [rtl/eic_irq_channel.v]
// Request flag of one extra external interrupt input.
// Assumes pinLevel is already synchronised; ack is a one-cycle service pulse.
`timescale 1ns/10ps

module eic_irq_channel (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Request pin, synchronised, active low
    input wire pinLevel,
    // Control
    input wire edgeSelect,
    input wire ack,
    input wire swWrite,
    input wire swValue,
    // Flag
    output reg requestFlag
);

    reg pinPrev;
    reg next_requestFlag;
    wire fallEdge;

    assign fallEdge = pinPrev & ~pinLevel;

    always @* begin
        if (edgeSelect) begin
            // Detected edge wins over service or software clear in the same cycle
            if (fallEdge) begin
                next_requestFlag = 1'b1; // [RULE5] [RULE9] [RULE6] [RULE10]
            end else if (swWrite) begin
                next_requestFlag = swValue;
            end else if (ack) begin
                next_requestFlag = 1'b0; // [RULE5] [RULE9]
            end else begin
                next_requestFlag = requestFlag;
            end
        end else begin
            // Low level mode: flag follows the pin, service does not clear it
            next_requestFlag = ~pinLevel; // [RULE6] [RULE10]
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinPrev <= 1'b1;
            requestFlag <= 1'b0;
        end else begin
            pinPrev <= pinLevel;
            requestFlag <= next_requestFlag;
        end
    end

endmodule // eic_irq_channel

// [rtl/eic_control.v]
// Extra external interrupt control register, nibble I/O port and request selection.
// Assumes the core gives byte and single-bit strobes on the SFR bus, one cycle each,
// and pulses a per-source acknowledge when it enters the handler.
//
// What this block does
// RULE1 - The control register sits at SFR address 0C0H with byte access and bit set and clear.
// RULE2 - A bit set at bit address 0C2H sets the enable bit of request input A.
// RULE3 - Input B requests are high priority when its priority bit is one, else low priority.
// RULE4 - A pending input B request reaches the core only while the input B enable bit is set.
// RULE5 - In edge mode hardware sets the input B flag on an edge and clears it on service.
// RULE6 - Input B triggers on a falling edge when its select bit is one, else on a low level.
// RULE7 - Input A requests are high priority when its priority bit is one, else low priority.
// RULE8 - A pending input A request reaches the core only while the input A enable bit is set.
// RULE9 - In edge mode hardware sets the input A flag on an edge and clears it on service.
// RULE10 - Input A triggers on a falling edge when its select bit is one, else on a low level.
// RULE11 - Port pins 3 and 2 serve as ordinary I/O or as the request inputs B and A.
// RULE12 - Input A vectors to 33H and is polled seventh within its priority level.
// RULE13 - Input B vectors to 3BH and is polled last of eight within its priority level.
// RULE14 - In level mode the source holds its line low until the handler responds, then lets go.
`timescale 1ns/10ps
`include "eic_map.vh"

module eic_control (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // SFR byte access
    input wire [7:0] sfrAddr,
    input wire sfrWrite,
    input wire sfrRead,
    input wire [7:0] sfrWrData,
    output reg [7:0] sfrRdData,
    output reg sfrRdHit,
    // SFR bit access
    input wire [7:0] bitAddr,
    input wire bitSet,
    input wire bitClear,
    input wire bitRead,
    output reg bitRdData,
    output reg bitRdHit,
    // Nibble I/O port pins
    input wire [3:0] portPinIn,
    output wire [3:0] portPinOut,
    output wire [3:0] portPinOe,
    // Requests to the core
    output reg irqAReq,
    output reg irqBReq,
    output reg irqAHigh,
    output reg irqBHigh,
    output reg irqValid,
    output reg irqHigh,
    output reg [7:0] irqVector,
    output reg [2:0] irqPollIndex,
    // Service acknowledges from the core
    input wire irqAAck,
    input wire irqBAck
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [7:0] controlBits;
    reg [3:0] portLatch;
    wire [3:0] pinSync;
    wire flagA;
    wire flagB;
    wire [7:0] controlView;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire byteHitCtl;
    wire byteHitPort;
    wire bitHitCtl;
    wire bitHitPort;
    wire [2:0] bitIndex;

    assign byteHitCtl = (sfrAddr == `EIC_XCTL_ADDR); // [RULE1]
    assign byteHitPort = (sfrAddr == `EIC_PORT_ADDR);
    assign bitIndex = bitAddr[2:0];
    assign bitHitCtl = ((bitAddr & `EIC_ADDR_BASE_MASK) == `EIC_XCTL_ADDR); // [RULE1]
    assign bitHitPort = ((bitAddr & `EIC_ADDR_BASE_MASK) == `EIC_PORT_ADDR)
        && (bitIndex < `EIC_PORT_WIDTH);

    // ----------------------------------------------------------------
    // Write masks, shared by byte and bit access
    // ----------------------------------------------------------------
    reg [7:0] ctlMask;
    reg [7:0] ctlValue;
    reg [3:0] portMask;
    reg [3:0] portValue;
    reg [7:0] bitOneHot;

    always @* begin
        bitOneHot = 8'h01 << bitIndex;
        ctlMask = 8'h00;
        ctlValue = 8'h00;
        portMask = 4'h0;
        portValue = 4'h0;
        if (sfrWrite && byteHitCtl) begin
            ctlMask = 8'hFF; // [RULE1]
            ctlValue = sfrWrData;
        end else if ((bitSet || bitClear) && bitHitCtl) begin
            // Single-bit set or clear; set wins if both strobes arrive
            ctlMask = bitOneHot; // [RULE1] [RULE2]
            ctlValue = bitSet ? 8'hFF : 8'h00;
        end
        if (sfrWrite && byteHitPort) begin
            portMask = 4'hF;
            portValue = sfrWrData[3:0];
        end else if ((bitSet || bitClear) && bitHitPort) begin
            portMask = bitOneHot[3:0];
            portValue = bitSet ? 4'hF : 4'h0;
        end
    end

    // ----------------------------------------------------------------
    // Control bits and port latch
    // ----------------------------------------------------------------
    wire [7:0] next_controlBits;
    wire [3:0] next_portLatch;

    assign next_controlBits = (controlBits & ~ctlMask) | (ctlValue & ctlMask); // [RULE1] [RULE2]
    assign next_portLatch = (portLatch & ~portMask) | (portValue & portMask);

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            controlBits <= `EIC_XCTL_RESET;
        end else begin
            controlBits <= next_controlBits;
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            portLatch <= `EIC_PORT_RESET;
        end else begin
            portLatch <= next_portLatch;
        end
    end

    // ----------------------------------------------------------------
    // Pins: quasi-bidirectional, driven low when the latch holds zero
    // ----------------------------------------------------------------
    assign portPinOut = 4'h0;
    // A pin used as a request input needs its latch bit at one, or the port pulls it low
    assign portPinOe = ~portLatch; // [RULE11]

    // ----------------------------------------------------------------
    // Pin synchroniser: the pins arrive from outside the core clock domain
    // ----------------------------------------------------------------
    eic_sync #(
        .WIDTH(`EIC_PORT_WIDTH),
        .RESET_VALUE(`EIC_PORT_RESET)
    ) u_pinSync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .asyncIn(portPinIn),
        .syncOut(pinSync)
    );

    // ----------------------------------------------------------------
    // Request flags
    // ----------------------------------------------------------------
    eic_irq_channel u_chanA (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pinLevel(pinSync[`EIC_PIN_A]), // [RULE11]
        .edgeSelect(controlBits[`EIC_A_EDGE_SELECT]), // [RULE10]
        .ack(irqAAck), // [RULE9]
        .swWrite(ctlMask[`EIC_A_REQUEST_FLAG]),
        .swValue(ctlValue[`EIC_A_REQUEST_FLAG]),
        .requestFlag(flagA)
    );

    eic_irq_channel u_chanB (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pinLevel(pinSync[`EIC_PIN_B]), // [RULE11]
        .edgeSelect(controlBits[`EIC_B_EDGE_SELECT]), // [RULE6]
        .ack(irqBAck), // [RULE5]
        .swWrite(ctlMask[`EIC_B_REQUEST_FLAG]),
        .swValue(ctlValue[`EIC_B_REQUEST_FLAG]),
        .requestFlag(flagB)
    );

    // ----------------------------------------------------------------
    // Register view
    // ----------------------------------------------------------------
    // Flags live in the channels; the stored copies of those bits are not used
    assign controlView = {controlBits[7:6], flagB, controlBits[4:2], flagA, controlBits[0]};

    // ----------------------------------------------------------------
    // Request selection
    // ----------------------------------------------------------------
    reg next_valid;
    reg next_high;
    reg [7:0] next_vector;
    reg [2:0] next_poll;
    wire pendA;
    wire pendB;
    wire highA;
    wire highB;

    assign pendA = flagA & controlBits[`EIC_A_ENABLE]; // [RULE8]
    assign pendB = flagB & controlBits[`EIC_B_ENABLE]; // [RULE4]
    assign highA = pendA & controlBits[`EIC_A_PRIORITY_HIGH]; // [RULE7]
    assign highB = pendB & controlBits[`EIC_B_PRIORITY_HIGH]; // [RULE3]

    always @* begin
        next_valid = 1'b1;
        next_high = 1'b0;
        next_vector = 8'h00;
        next_poll = 3'h0;
        // High level first, then polling order A before B
        // Outputs are registered, so they trail the flags by one cycle
        if (highA) begin
            next_high = 1'b1;
            next_vector = `EIC_A_VECTOR; // [RULE12]
            next_poll = `EIC_A_POLL;
        end else if (highB) begin
            next_high = 1'b1;
            next_vector = `EIC_B_VECTOR; // [RULE13]
            next_poll = `EIC_B_POLL;
        end else if (pendA) begin
            next_vector = `EIC_A_VECTOR; // [RULE12]
            next_poll = `EIC_A_POLL;
        end else if (pendB) begin
            next_vector = `EIC_B_VECTOR; // [RULE13]
            next_poll = `EIC_B_POLL;
        end else begin
            next_valid = 1'b0;
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqAReq <= 1'b0;
            irqBReq <= 1'b0;
            irqAHigh <= 1'b0;
            irqBHigh <= 1'b0;
            irqValid <= 1'b0;
            irqHigh <= 1'b0;
            irqVector <= 8'h00;
            irqPollIndex <= 3'h0;
        end else begin
            irqAReq <= pendA; // [RULE8]
            irqBReq <= pendB; // [RULE4]
            irqAHigh <= controlBits[`EIC_A_PRIORITY_HIGH]; // [RULE7]
            irqBHigh <= controlBits[`EIC_B_PRIORITY_HIGH]; // [RULE3]
            irqValid <= next_valid;
            irqHigh <= next_high;
            irqVector <= next_vector;
            irqPollIndex <= next_poll;
        end
    end

    // ----------------------------------------------------------------
    // Read path: port reads return pin levels, unmapped reads zero
    // ----------------------------------------------------------------
    reg [7:0] next_rdData;
    reg next_rdHit;
    reg next_bitData;
    reg next_bitHit;
    wire [7:0] portView;

    assign portView = {4'h0, pinSync};

    always @* begin
        next_rdData = 8'h00;
        next_rdHit = 1'b0;
        if (sfrRead && byteHitCtl) begin
            next_rdData = controlView; // [RULE1]
            next_rdHit = 1'b1;
        end else if (sfrRead && byteHitPort) begin
            next_rdData = portView; // [RULE11]
            next_rdHit = 1'b1;
        end
    end

    always @* begin
        next_bitData = 1'b0;
        next_bitHit = 1'b0;
        if (bitRead && bitHitCtl) begin
            next_bitData = controlView[bitIndex];
            next_bitHit = 1'b1;
        end else if (bitRead && bitHitPort) begin
            next_bitData = portView[bitIndex];
            next_bitHit = 1'b1;
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sfrRdData <= 8'h00;
            sfrRdHit <= 1'b0;
            bitRdData <= 1'b0;
            bitRdHit <= 1'b0;
        end else begin
            sfrRdData <= next_rdData;
            sfrRdHit <= next_rdHit;
            bitRdData <= next_bitData;
            bitRdHit <= next_bitHit;
        end
    end

endmodule // eic_control

// [verification/eic_irq_source.sv]
// Far-side model: two request sources pulling the interrupt pins low.
// Assumes the bench pulses pull and ack for one cycle each; released lines float high.
`timescale 1ns/10ps

module eic_irq_source (
    // Clock
    input wire core_clk,
    // Commands and handler acknowledges
    input wire [1:0] pull,
    input wire [1:0] ack,
    input wire slow,
    // High while the line is held low
    output reg [1:0] pinLow
);
    reg [1:0] ackLate;
    initial pinLow = 2'b00;
    initial ackLate = 2'b00;
    // Held low until the handler responds, released at once or one cycle late
    always @(posedge core_clk) begin
        ackLate <= ack & {2{slow}};
        pinLow <= (pinLow | pull) & ~((ack & {2{!slow}}) | ackLate);
    end
endmodule // eic_irq_source

// [verification/eic_control_sva.sv]
// Port assertions for eic_control, bound into every instance.
// Assumes one clock domain; a shadow of the software bits follows bus writes.
`timescale 1ns/10ps

module eic_control_sva (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Register bus
    input wire [7:0] sfrAddr,
    input wire sfrWrite,
    input wire sfrRead,
    input wire [7:0] sfrWrData,
    input wire [7:0] sfrRdData,
    input wire sfrRdHit,
    input wire [7:0] bitAddr,
    input wire bitSet,
    input wire bitClear,
    // Pins and requests
    input wire [3:0] portPinIn,
    input wire irqAReq,
    input wire irqBReq,
    input wire irqAHigh,
    input wire irqBHigh,
    input wire irqHigh,
    input wire [7:0] irqVector,
    input wire [2:0] irqPollIndex,
    input wire irqAAck
);
    reg [7:0] ctl;
    // Byte write wins over a bit operation
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl <= 8'h00;
        end else if (sfrWrite && sfrAddr == 8'hC0) begin
            ctl <= sfrWrData;
        end else if ((bitSet || bitClear) && bitAddr[7:3] == 5'h18) begin
            ctl[bitAddr[2:0]] <= bitSet;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence fallA; ctl[0] && ctl[2] && $fell(portPinIn[2]); endsequence
    sequence fallB; ctl[4] && ctl[6] && $fell(portPinIn[3]); endsequence
    read_miss_a:
        assert property (sfrRead && sfrAddr != 8'hC0 && sfrAddr != 8'hD8
            |=> sfrRdData == 8'h00 && !sfrRdHit) else $error("unmapped read answered");
    pick_a_a:
        assert property (irqAReq && (irqAHigh || !(irqBReq && irqBHigh)) |-> irqVector == 8'h33
            && irqPollIndex == 3'h6 && irqHigh == irqAHigh) else $error("input A selection");
    pick_b_a:
        assert property (irqBReq && !(irqAReq && (irqAHigh || !irqBHigh)) |-> irqVector == 8'h3B
            && irqPollIndex == 3'h7 && irqHigh == irqBHigh) else $error("input B selection");
    gate_a_a:
        assert property (!ctl[2] |=> !irqAReq) else $error("disabled A forwarded");
    gate_b_a:
        assert property (!ctl[6] |=> !irqBReq) else $error("disabled B forwarded");
    prio_copy_a:
        assert property (irqAHigh == $past(ctl[3]) && irqBHigh == $past(ctl[7]))
            else $error("priority level wrong");
    edge_a_a:
        assert property (fallA |-> ##[3:6] irqAReq) else $error("A edge missed");
    edge_b_a:
        assert property (fallB |-> ##[3:6] irqBReq) else $error("B edge missed");
    serve_clear_a:
        assert property (ctl[0] && irqAAck |-> ##2 !irqAReq) else $error("A flag not cleared");
endmodule // eic_control_sva

bind eic_control eic_control_sva chk (.core_clk, .rst_b, .sfrAddr, .sfrWrite, .sfrRead,
    .sfrWrData, .sfrRdData, .sfrRdHit, .bitAddr, .bitSet, .bitClear, .portPinIn, .irqAReq,
    .irqBReq, .irqAHigh, .irqBHigh, .irqHigh, .irqVector, .irqPollIndex, .irqAAck);

// [verification/test_ext_interrupt_2_3_control.sv]
// Self-checking bench for eic_control with a request source model on the pins.
// Assumes the checker is bound in; the port pins have pull-ups.
`timescale 1ns/10ps

module test_ext_interrupt_2_3_control;
    reg core_clk, rst_b, sfrWrite, sfrRead, bitSet, bitClear, bitRead, slow;
    reg [7:0] sfrAddr, sfrWrData, bitAddr, mctl;
    reg [3:0] mport;
    reg [31:0] rnd;
    reg [1:0] tbLow, pull, ack;
    wire [7:0] sfrRdData, irqVector;
    wire [3:0] portPinIn, portPinOut, portPinOe;
    wire [2:0] irqPollIndex;
    wire [1:0] pinLow;
    wire sfrRdHit, bitRdData, bitRdHit, irqAReq, irqBReq, irqAHigh, irqBHigh, irqValid, irqHigh;
    integer bad_count, tests_run, seed, i, j;
    // Wired level: any party driving low wins over the pull-up
    assign portPinIn = ~(portPinOe | {pinLow, tbLow});
    eic_control dut (.core_clk, .rst_b, .sfrAddr, .sfrWrite, .sfrRead, .sfrWrData, .sfrRdData,
        .sfrRdHit, .bitAddr, .bitSet, .bitClear, .bitRead, .bitRdData, .bitRdHit, .portPinIn,
        .portPinOut, .portPinOe, .irqAReq, .irqBReq, .irqAHigh, .irqBHigh, .irqValid, .irqHigh,
        .irqVector, .irqPollIndex, .irqAAck(ack[0]), .irqBAck(ack[1]));
    eic_irq_source src (.core_clk, .pull, .ack, .slow, .pinLow);

    task chk(input string name, input [7:0] seen, input [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge core_clk);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWrite <= 1'b1;
        @(posedge core_clk);
        sfrWrite <= 1'b0;
        if (a == 8'hC0) mctl = d;
        if (a == 8'hD8) mport = d[3:0];
    endtask
    task rd(input [7:0] a, input [7:0] e, input h);
        @(posedge core_clk);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge core_clk);
        sfrRead <= 1'b0;
        #1;
        chk("read data", sfrRdData, e);
        chk("read hit", sfrRdHit, h);
    endtask
    task bop(input [7:0] a, input s);
        @(posedge core_clk);
        bitAddr <= a;
        bitSet <= s;
        bitClear <= !s;
        @(posedge core_clk);
        bitSet <= 1'b0;
        bitClear <= 1'b0;
        if (a[7:3] == 5'h18) mctl[a[2:0]] = s;
        if (a[7:2] == 6'h36) mport[a[1:0]] = s;
    endtask
    task pulse(input [1:0] p);
        @(posedge core_clk);
        pull <= p;
        @(posedge core_clk);
        pull <= 2'b00;
    endtask
    task irq(input [1:0] p, input [7:0] v, input hi);
        pulse(p);
        for (j = 0; j < 8 && irqValid !== 1'b1; j = j + 1) @(posedge core_clk);
        #1;
        chk("valid", irqValid, 1);
        chk("vector", irqVector, v);
        chk("poll", irqPollIndex, v == 8'h33 ? 8'h06 : 8'h07);
        chk("high", irqHigh, hi);
        chk("requests", {irqBReq, irqAReq}, p);
        chk("levels", {irqBHigh, irqAHigh}, {mctl[7], mctl[3]});
    endtask
    task serve(input [1:0] a);
        @(posedge core_clk);
        ack <= a;
        @(posedge core_clk);
        ack <= 2'b00;
        repeat (6) @(posedge core_clk);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // About three hundred cycles are needed; twenty thousand means a hang
    initial begin
        #200000;
        bad_count = bad_count + 1;
        end_sim;
    end
    initial begin
        {rst_b, sfrWrite, sfrRead, bitSet, bitClear, bitRead, slow} = 7'h00;
        {sfrAddr, sfrWrData, bitAddr, tbLow, pull, ack} = 30'h0;
        bad_count = 0;
        tests_run = 0;
        seed = 34;
        mctl = 8'h00;
        mport = 4'hF;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(8'hC0, 8'h00, 1);
        rd(8'hD8, 8'h0F, 1);
        for (i = 0; i < 6; i = i + 1) begin
            rnd = $random(seed);
            wr(8'hC0, rnd[7:0] & 8'hDD);
            rd(8'hC0, mctl, 1);
        end
        wr(8'hC1, 8'hFF);
        rd(8'hC1, 8'h00, 0);
        rd(8'hC0, mctl, 1);
        wr(8'hC0, 8'h00);
        bop(8'hC2, 1);
        rd(8'hC0, 8'h04, 1);
        @(posedge core_clk);
        bitAddr <= 8'hC2;
        bitRead <= 1'b1;
        @(posedge core_clk);
        bitRead <= 1'b0;
        #1 chk("bit read", bitRdData, 1);
        chk("bit hit", bitRdHit, 1);
        for (i = 0; i < 16; i = i + 1) if (i % 4 != 1) begin
            bop(8'hC0 | i[2:0], i < 8);
            rd(8'hC0, mctl, 1);
        end
        wr(8'hC0, 8'h55);
        irq(2'b01, 8'h33, 0);
        rd(8'hC0, 8'h57, 1);
        serve(2'b01);
        rd(8'hC0, 8'h55, 1);
        irq(2'b10, 8'h3B, 0);
        rd(8'hC0, 8'h75, 1);
        serve(2'b10);
        bop(8'hC7, 1);
        irq(2'b11, 8'h3B, 1);
        serve(2'b10);
        #1 chk("vector", irqVector, 8'h33);
        serve(2'b01);
        bop(8'hC3, 1);
        irq(2'b11, 8'h33, 1);
        serve(2'b11);
        wr(8'hC0, 8'h11);
        pulse(2'b11);
        repeat (8) @(posedge core_clk);
        #1 chk("valid", irqValid, 0);
        rd(8'hC0, 8'h33, 1);
        serve(2'b11);
        rd(8'hC0, 8'h11, 1);
        wr(8'hC0, 8'h44);
        slow <= 1'b1;
        irq(2'b01, 8'h33, 0);
        rd(8'hC0, 8'h46, 1);
        serve(2'b01);
        irq(2'b10, 8'h3B, 0);
        serve(2'b10);
        rd(8'hC0, 8'h44, 1);
        wr(8'hC0, 8'h00);
        for (i = 0; i < 5; i = i + 1) begin
            rnd = $random(seed);
            tbLow <= rnd[1:0];
            wr(8'hD8, rnd[15:8]);
            bop(8'hD8 | rnd[18:16], rnd[19]);
            repeat (3) @(posedge core_clk);
            #1 chk("pin enable", portPinOe, {4'h0, ~mport});
            chk("pin out", portPinOut, 8'h00);
            rd(8'hD8, {4'h0, mport & {2'b11, ~tbLow}}, 1);
        end
        // Reset again in mid-run: register, latch and requests return to idle
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        mctl = 8'h00;
        mport = 4'hF;
        #1 chk("pin enable", portPinOe, 8'h00);
        chk("valid", irqValid, 0);
        rd(8'hC0, 8'h00, 1);
        rd(8'hD8, {4'h0, mport & {2'b11, ~tbLow}}, 1);
        end_sim;
    end
endmodule // test_ext_interrupt_2_3_control
